// *** rtl/acr_dev.sv ***
// Configuration register bank with decoded analog control outputs
module acr_dev #(
  parameter int NUM_CH = 8,
  parameter int CAL_LOG2 = acr_pkg::CAL_DIV_LOG2
) (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Async reset, active low
  acr_if.dev lnk, // Register link
  input wire logic drive_disconnect_pin, // Drive electrode comparator
  output logic test_internal, // Test signal generated inside
  output logic calibration_amplitude, // Double amplitude
  output logic calibration_wave, // Test waveform level
  output logic reference_buffer_enable, // Ref buffer on
  output logic high_reference_select, // 4V reference
  output logic drive_reference_internal, // Midsupply drive ref
  output logic drive_buffer_enable, // Drive buffer on
  output logic drive_sense_enable, // Drive sense on
  output logic [9:0] thr_pos_permille, // Positive threshold
  output logic [9:0] thr_neg_permille, // Negative threshold
  output logic resistor_detect_mode, // Resistor detection
  output logic [4:0] excitation_na, // Excitation current
  output logic detect_ac, // Ac detection on
  output logic detect_dc, // Dc detection on
  output logic [NUM_CH-1:0] channel_power_down, // Per channel
  output logic [NUM_CH-1:0][3:0] channel_gain, // Gain value
  output logic [NUM_CH-1:0][2:0] channel_input_select, // Mux
  output logic [NUM_CH-1:0] drive_input_route, // Drive to channel
  output logic [NUM_CH-1:0] drive_pos_sel, // Positive derivation
  output logic [NUM_CH-1:0] drive_neg_sel // Negative derivation
);
  import acr_pkg::*;

  localparam logic [7:0] CH_MASK = 8'((16'h1 << NUM_CH) - 16'h1);
  localparam logic [4:0] CH_END = 5'(int'(ADDR_CH_BASE) + NUM_CH);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] test_q;
  logic [7:0] ref_q;
  logic [7:0] det_q;
  logic [7:0] ch_q [NUM_CH];
  logic [7:0] pos_q;
  logic [7:0] neg_q;
  logic ack_q;
  logic [7:0] rdata_q;
  logic disc_s1_q;
  logic disc_s2_q;
  logic [CAL_LOG2-1:0] cal_cnt_q;

  logic take;
  logic is_ch;
  logic [4:0] ch_off;
  logic [7:0] rd_mux;

  assign take = lnk.req & ~ack_q;
  assign is_ch = (lnk.addr >= ADDR_CH_BASE) && (lnk.addr < CH_END);
  assign ch_off = lnk.addr - ADDR_CH_BASE;
  assign lnk.ack = ack_q;
  assign lnk.rdata = rdata_q;

  // ----------------------------------------------------------------
  // Link handshake: one ack per request, one cycle after it
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  // Pin comes from the analog side, so it is synchronised first
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      disc_s1_q <= 1'b0;
      disc_s2_q <= 1'b0;
    end else begin
      disc_s1_q <= drive_disconnect_pin;
      disc_s2_q <= disc_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      test_q <= RST_TEST_CFG;
      ref_q <= RST_REF_CFG;
      det_q <= RST_DETECT_CTL;
      pos_q <= RST_DRV_SEL;
      neg_q <= RST_DRV_SEL;
    end else if (take && lnk.wr) begin
      case (lnk.addr)
        ADDR_TEST_CFG: test_q <= lnk.wdata & MASK_TEST_CFG;
        ADDR_REF_CFG: ref_q <= lnk.wdata & MASK_REF_CFG;
        ADDR_DETECT_CTL: det_q <= lnk.wdata;
        ADDR_DRV_POS: pos_q <= lnk.wdata & CH_MASK;
        ADDR_DRV_NEG: neg_q <= lnk.wdata & CH_MASK;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_q[i] <= RST_CH;
      end
    end else if (take && lnk.wr && is_ch) begin
      ch_q[ch_off[2:0]] <= lnk.wdata & MASK_CH;
    end
  end

  // ----------------------------------------------------------------
  // Read back; absent registers and bits read zero
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    case (lnk.addr)
      ADDR_TEST_CFG: rd_mux = test_q;
      ADDR_REF_CFG: rd_mux = {ref_q[7:1], disc_s2_q};
      ADDR_DETECT_CTL: rd_mux = det_q;
      ADDR_DRV_POS: rd_mux = pos_q;
      ADDR_DRV_NEG: rd_mux = neg_q;
      default: begin
        if (is_ch) begin
          rd_mux = ch_q[ch_off[2:0]];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (take) begin
      rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Calibration waveform generator
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cal_cnt_q <= '0;
    end else begin
      cal_cnt_q <= cal_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      calibration_wave <= 1'b0;
    end else begin
      case (test_q[TST_FREQ_LO +: 2])
        FREQ_SLOW: calibration_wave <= cal_cnt_q[CAL_LOG2-1];
        FREQ_FAST: calibration_wave <= cal_cnt_q[CAL_LOG2-2];
        FREQ_DC: calibration_wave <= 1'b1;
        default: calibration_wave <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Global control decode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      test_internal <= 1'b0;
      calibration_amplitude <= 1'b0;
      reference_buffer_enable <= 1'b0;
      high_reference_select <= 1'b0;
      drive_reference_internal <= 1'b0;
      drive_buffer_enable <= 1'b0;
      drive_sense_enable <= 1'b0;
    end else begin
      test_internal <= test_q[TST_INTERNAL];
      calibration_amplitude <= test_q[TST_AMP];
      reference_buffer_enable <= ref_q[REF_BUF_EN];
      // Needs a 5V analog supply; not checked here
      high_reference_select <= ref_q[REF_HIGH];
      drive_reference_internal <= ref_q[REF_DRV_INT];
      drive_buffer_enable <= ref_q[REF_DRV_BUF];
      drive_sense_enable <= ref_q[REF_DRV_SENSE];
    end
  end

  // ----------------------------------------------------------------
  // Electrode detection decode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      thr_pos_permille <= 10'h3B6;
      thr_neg_permille <= 10'h032;
      resistor_detect_mode <= 1'b0;
      excitation_na <= EXCITE_STEP_NA;
      detect_ac <= 1'b0;
      detect_dc <= 1'b0;
    end else begin
      case (det_q[DET_THR_LO +: 3])
        3'h0: thr_pos_permille <= 10'h3B6;
        3'h1: thr_pos_permille <= 10'h39D;
        3'h2: thr_pos_permille <= 10'h384;
        3'h3: thr_pos_permille <= 10'h36B;
        3'h4: thr_pos_permille <= 10'h352;
        3'h5: thr_pos_permille <= 10'h320;
        3'h6: thr_pos_permille <= 10'h2EE;
        default: thr_pos_permille <= 10'h2BC;
      endcase
      thr_neg_permille <= 10'h3E8 - thr_pos_permille;
      resistor_detect_mode <= det_q[DET_RES_MODE];
      excitation_na <= 5'(EXCITE_STEP_NA * (det_q[DET_CUR_LO +: 2] + 3'h1));
      detect_ac <= det_q[DET_FREQ_LO +: 2] == DETF_AC;
      detect_dc <= det_q[DET_FREQ_LO +: 2] == DETF_DC;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel decode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      channel_power_down <= '0;
      channel_gain <= {NUM_CH{4'h6}};
      channel_input_select <= '0;
      drive_input_route <= '0;
      drive_pos_sel <= '0;
      drive_neg_sel <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        channel_power_down[i] <= ch_q[i][CH_PD];
        case (ch_q[i][CH_GAIN_LO +: 3])
          3'h0: channel_gain[i] <= 4'h6;
          3'h1: channel_gain[i] <= 4'h1;
          3'h2: channel_gain[i] <= 4'h2;
          3'h3: channel_gain[i] <= 4'h3;
          3'h4: channel_gain[i] <= 4'h4;
          3'h5: channel_gain[i] <= 4'h8;
          3'h6: channel_gain[i] <= 4'hC;
          default: channel_gain[i] <= 4'h0;
        endcase
        channel_input_select[i] <= ch_q[i][CH_SEL_LO +: 3];
        drive_input_route[i] <= ref_q[REF_MEASURE] &&
                                (ch_q[i][CH_SEL_LO +: 3] == SEL_DRIVE_MEAS);
        drive_pos_sel[i] <= pos_q[i];
        drive_neg_sel[i] <= neg_q[i];
      end
    end
  end
endmodule : acr_dev

// *** rtl/acr_pkg.sv ***
// Constants shared by the configuration register bank and its controller
// What this block does
// - Test source bit 4: external or internal
// - Amplitude bit 2: one or two times
// - Frequency: div 2^21, 2^20, unused, dc
// - Host writes zero to bits 7:5,3
// - Reference buffer enable bit 7, default off
// - Reference bit 6 resets one, host writes one
// - Reference level bit 5: 2.4V or 4V
// - Measure bit routes drive input to mux 010
// - Drive reference bit 3: external or midsupply
// - Drive buffer bit 2, drive sense bit 1
// - Bit 0 reports drive electrode disconnected
// - Threshold codes map to fixed percentages
// - Detect method bit 4: current or resistor
// - Excitation current 6, 12, 18, 24 nA
// - Detect frequency: ac quarter rate, dc
// - Host programs 01/11 while sensing enabled
// - Channel bit 7 powers channel down
// - Channel gain field bits 6:4 decode
// - Channel input select bits 2:0 decode
// - Host writes zero to channel bit 3
// - Select bit k picks channel k+1
// - Missing channels' select bits do not exist
package acr_pkg;
  // ----------------------------------------------------------------
  // Register addresses on the link
  // ----------------------------------------------------------------
  localparam int LINK_AW = 5;
  localparam logic [4:0] ADDR_TEST_CFG = 5'h02;
  localparam logic [4:0] ADDR_REF_CFG = 5'h03;
  localparam logic [4:0] ADDR_DETECT_CTL = 5'h04;
  localparam logic [4:0] ADDR_CH_BASE = 5'h05;
  localparam logic [4:0] ADDR_DRV_POS = 5'h0D;
  localparam logic [4:0] ADDR_DRV_NEG = 5'h0E;
  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TEST_CFG = 8'h00;
  localparam logic [7:0] RST_REF_CFG = 8'h40;
  localparam logic [7:0] RST_DETECT_CTL = 8'h00;
  localparam logic [7:0] RST_CH = 8'h00;
  localparam logic [7:0] RST_DRV_SEL = 8'h00;
  localparam logic [7:0] MASK_TEST_CFG = 8'h17;
  localparam logic [7:0] MASK_REF_CFG = 8'hFE;
  localparam logic [7:0] MASK_CH = 8'hF7;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TST_INTERNAL = 4;
  localparam int TST_AMP = 2;
  localparam int TST_FREQ_LO = 0;
  localparam int REF_BUF_EN = 7;
  localparam int REF_FIXED_ONE = 6;
  localparam int REF_HIGH = 5;
  localparam int REF_MEASURE = 4;
  localparam int REF_DRV_INT = 3;
  localparam int REF_DRV_BUF = 2;
  localparam int REF_DRV_SENSE = 1;
  localparam int REF_DISCONNECT = 0;
  localparam int DET_THR_LO = 5;
  localparam int DET_RES_MODE = 4;
  localparam int DET_CUR_LO = 2;
  localparam int DET_FREQ_LO = 0;
  localparam int CH_PD = 7;
  localparam int CH_GAIN_LO = 4;
  localparam int CH_ZERO = 3;
  localparam int CH_SEL_LO = 0;
  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] FREQ_SLOW = 2'h0;
  localparam logic [1:0] FREQ_FAST = 2'h1;
  localparam logic [1:0] FREQ_DC = 2'h3;
  localparam logic [1:0] DETF_AC = 2'h1;
  localparam logic [1:0] DETF_DC = 2'h3;
  localparam logic [2:0] SEL_DRIVE_MEAS = 3'h2;
  localparam int CAL_DIV_LOG2 = 21;
  localparam logic [4:0] EXCITE_STEP_NA = 5'h06;
  // ----------------------------------------------------------------
  // Controller register map (Avalon word addresses)
  // ----------------------------------------------------------------
  localparam int AVS_AW = 6;
  localparam logic [5:0] AVS_CTRL = 6'h20;
  localparam logic [5:0] AVS_STATUS = 6'h21;
  localparam int CTRL_SENSE_ACTIVE = 0;
  localparam int STAT_COERCED = 0;
endpackage : acr_pkg

// *** rtl/acr_if.sv ***
// Register link between the configuration bank and its controller
interface acr_if;
  logic req;
  logic wr;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
  modport ctl (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface : acr_if

// *** rtl/acr_host.sv ***
// Controller end: Avalon-MM slave bridging software to the register link
module acr_host (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [acr_pkg::AVS_AW-1:0] avs_address, // Word address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall, low for one cycle to finish
  acr_if.ctl lnk // Register link
);
  import acr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LINK = 3'b010,
    ST_RESP = 3'b100
  } acr_state_e;

  acr_state_e state_q;
  logic req_q;
  logic wr_q;
  logic [4:0] addr_q;
  logic [7:0] wdata_q;
  logic sense_active_q;
  logic coerced_q;
  logic is_link;
  logic [7:0] fixed;
  logic fix_hit;

  assign lnk.req = req_q;
  assign lnk.wr = wr_q;
  assign lnk.addr = addr_q;
  assign lnk.wdata = wdata_q;
  assign is_link = ~avs_address[AVS_AW-1];

  // ----------------------------------------------------------------
  // Force fixed bits so software slips never reach the bank
  // ----------------------------------------------------------------
  always_comb begin
    fixed = avs_writedata[7:0];
    fix_hit = 1'b0;
    if (avs_address[4:0] == ADDR_TEST_CFG) begin
      fixed = fixed & MASK_TEST_CFG;
    end else if (avs_address[4:0] == ADDR_REF_CFG) begin
      fixed[REF_FIXED_ONE] = 1'b1;
    end else if (avs_address[4:0] >= ADDR_CH_BASE && avs_address[4:0] < ADDR_DRV_POS) begin
      fixed[CH_ZERO] = 1'b0;
    end else if (avs_address[4:0] == ADDR_DETECT_CTL && sense_active_q) begin
      // Illegal codes while sensing fall back to dc detection
      if (fixed[DET_FREQ_LO +: 2] != DETF_AC && fixed[DET_FREQ_LO +: 2] != DETF_DC) begin
        fixed[DET_FREQ_LO +: 2] = DETF_DC;
        fix_hit = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 5'h00;
      wdata_q <= 8'h00;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (avs_read || avs_write) begin
            if (is_link) begin
              req_q <= 1'b1;
              wr_q <= avs_write;
              addr_q <= avs_address[4:0];
              wdata_q <= fixed;
              state_q <= ST_LINK;
            end else begin
              case (avs_address)
                AVS_CTRL: avs_readdata <= {31'h0, sense_active_q};
                AVS_STATUS: avs_readdata <= {31'h0, coerced_q};
                default: avs_readdata <= 32'h0000_0000;
              endcase
              avs_waitrequest <= 1'b0;
              state_q <= ST_RESP;
            end
          end
        end
        ST_LINK: begin
          if (lnk.ack) begin
            req_q <= 1'b0;
            avs_readdata <= {24'h00_0000, lnk.rdata};
            avs_waitrequest <= 1'b0;
            state_q <= ST_RESP;
          end
        end
        ST_RESP: begin
          avs_waitrequest <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Own registers; writes land on the accepting edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sense_active_q <= 1'b0;
    end else if (state_q == ST_RESP && avs_write && avs_address == AVS_CTRL) begin
      sense_active_q <= avs_writedata[CTRL_SENSE_ACTIVE];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      coerced_q <= 1'b0;
    end else if (state_q == ST_IDLE && avs_write && is_link && fix_hit) begin
      coerced_q <= 1'b1;
    end else if (state_q == ST_RESP && avs_write && avs_address == AVS_STATUS &&
                 avs_writedata[STAT_COERCED]) begin
      coerced_q <= 1'b0;
    end
  end
endmodule : acr_host

// *** verification/acr_link_sva.sv ***
// Link protocol and host-side field checks on the register link
module acr_link_sva import acr_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic req, // Link request
  input wire logic wr, // Link write
  input wire logic [4:0] addr, // Link address
  input wire logic [7:0] wdata, // Link write data
  input wire logic ack, // Link answer
  input wire logic [7:0] rdata // Link read data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic wr_put;
  logic rd_ack;
  assign wr_put = req && wr && !ack;
  assign rd_ack = ack && !wr;
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("link ack held beyond one cycle");
  a_ack_follows: assert property (req && !ack |=> ack)
    else $error("link ack missing one cycle after request");
  a_req_release: assert property (ack |=> !req)
    else $error("link request not dropped after ack");
  a_test_zero: assert property (wr_put && addr == ADDR_TEST_CFG |-> (wdata & 8'hE8) == 8'h00)
    else $error("test config written with reserved bits set");
  a_ref_one: assert property (wr_put && addr == ADDR_REF_CFG |-> wdata[6])
    else $error("reference config written with bit 6 clear");
  a_chan_zero: assert property (wr_put && addr >= 5'h05 && addr <= 5'h0C |-> !wdata[3])
    else $error("channel setting written with bit 3 set");
  a_ref_read: assert property (rd_ack && addr == ADDR_REF_CFG |-> rdata[6])
    else $error("reference config read with bit 6 clear");
  a_hole_zero: assert property (rd_ack && (addr < 5'h02 || addr > 5'h0E) |-> rdata == 8'h00)
    else $error("unmapped link address read nonzero");
endmodule : acr_link_sva

// *** verification/tb_afe_channel_config_regs.sv ***
// Self-checking bench: controller and register bank joined over the link
module tb_afe_channel_config_regs import acr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NC = 6;
  localparam int CL = 4;
  logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest, drive_disconnect_pin;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic test_internal, calibration_amplitude, calibration_wave, reference_buffer_enable, high_reference_select;
  logic drive_reference_internal, drive_buffer_enable, drive_sense_enable, resistor_detect_mode, detect_ac, detect_dc;
  logic [9:0] thr_pos_permille, thr_neg_permille;
  logic [4:0] excitation_na;
  logic [NC-1:0] channel_power_down, drive_input_route, drive_pos_sel, drive_neg_sel;
  logic [NC-1:0][3:0] channel_gain;
  logic [NC-1:0][2:0] channel_input_select;
  logic [7:0] sh [32];
  logic [31:0] exp_q [$];
  logic [31:0] rs = 32'h0000000C;
  logic [9:0] thr [8] = '{10'h3B6, 10'h39D, 10'h384, 10'h36B, 10'h352, 10'h320, 10'h2EE, 10'h2BC};
  logic [3:0] gtab [8] = '{4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC, 4'h0};
  int fail_count = 0;
  int num_checks = 0;
  acr_if acr_if_i ();
  acr_host acr_host_i (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lnk(acr_if_i));
  acr_dev #(.NUM_CH(NC), .CAL_LOG2(CL)) acr_dev_i (.clk_sys(clk_sys), .nrst(nrst), .lnk(acr_if_i),
    .drive_disconnect_pin(drive_disconnect_pin), .test_internal(test_internal),
    .calibration_amplitude(calibration_amplitude), .calibration_wave(calibration_wave),
    .reference_buffer_enable(reference_buffer_enable), .high_reference_select(high_reference_select),
    .drive_reference_internal(drive_reference_internal), .drive_buffer_enable(drive_buffer_enable),
    .drive_sense_enable(drive_sense_enable), .thr_pos_permille(thr_pos_permille),
    .thr_neg_permille(thr_neg_permille), .resistor_detect_mode(resistor_detect_mode),
    .excitation_na(excitation_na), .detect_ac(detect_ac), .detect_dc(detect_dc),
    .channel_power_down(channel_power_down), .channel_gain(channel_gain),
    .channel_input_select(channel_input_select), .drive_input_route(drive_input_route),
    .drive_pos_sel(drive_pos_sel), .drive_neg_sel(drive_neg_sel));
  acr_link_sva acr_link_sva_i (.clk_sys(clk_sys), .nrst(nrst), .req(acr_if_i.req), .wr(acr_if_i.wr),
    .addr(acr_if_i.addr), .wdata(acr_if_i.wdata), .ack(acr_if_i.ack), .rdata(acr_if_i.rdata));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Stored value of a link register after a write, pin bit excluded
  function automatic logic [7:0] ev(input logic [4:0] a, input logic [7:0] d);
    if (a == 5'h02) return d & 8'h17;
    if (a == 5'h03) return (d & 8'hFE) | 8'h40;
    if (a == 5'h04) return d;
    if (a == 5'h0D || a == 5'h0E) return d & 8'h3F;
    if (a >= 5'h05 && a < 5'h05 + NC) return d & 8'hF7;
    return 8'h00;
  endfunction : ev
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // Starts one edge after entry so release and next request never share a time step
  // Waits for the answer however long it takes; only the watchdog ends a hang
  task automatic av(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    av(1'b0, a, 32'h0);
  endtask : rd
  task automatic wl(input logic [4:0] a, input logic [7:0] d);
    sh[a] = ev(a, d);
    av(1'b1, {1'b0, a}, {24'h0, d});
    repeat (2) @(posedge clk_sys);
  endtask : wl
  task automatic co;
    logic [7:0] c;
    chk({test_internal, calibration_amplitude}, {sh[2][4], sh[2][2]});
    chk({reference_buffer_enable, high_reference_select, drive_reference_internal, drive_buffer_enable,
      drive_sense_enable}, {sh[3][7], sh[3][5], sh[3][3:1]});
    chk({thr_pos_permille, thr_neg_permille}, {thr[sh[4][7:5]], 10'h3E8 - thr[sh[4][7:5]]});
    chk({resistor_detect_mode, excitation_na, detect_ac, detect_dc}, {sh[4][4], 5'h06 * ({3'h0, sh[4][3:2]} + 5'h01),
      sh[4][1:0] == 2'h1, sh[4][1:0] == 2'h3});
    for (int k = 0; k < NC; k++) begin
      c = sh[5 + k];
      chk({channel_power_down[k], channel_gain[k], channel_input_select[k], drive_input_route[k], drive_pos_sel[k],
        drive_neg_sel[k]}, {c[7], gtab[c[6:4]], c[2:0], sh[3][4] && c[2:0] == 3'h2, sh[13][k], sh[14][k]});
    end
  endtask : co
  // ----------------------------------------------------------------
  // Read result monitor
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      chk(avs_readdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hXXXXXXXX);
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    $display("wrong value at %0t: got %0h expected %0h", $time, 0, 1);
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [5:0] rise, high;
    logic prev;
    nrst = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    drive_disconnect_pin = 1'b0;
    foreach (sh[i]) sh[i] = 8'h00;
    sh[3] = 8'h40;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int a = 0; a < 32; a++) rd(6'(a), {24'h0, sh[a]});
    co();
    for (int r = 0; r < 3; r++) begin
      for (int a = 0; a < 32; a++) begin
        rs = xs(rs);
        wl(5'(a), rs[7:0]);
        rd(6'(a), {24'h0, sh[a]});
        co();
      end
    end
    // Mid-run reset must bring every written field back to its default
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (sh[i]) sh[i] = 8'h00;
    sh[3] = 8'h40;
    for (int a = 0; a < 32; a++) rd(6'(a), {24'h0, sh[a]});
    co();
    drive_disconnect_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(6'h03, {24'h0, sh[3] | 8'h01});
    drive_disconnect_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(6'h03, {24'h0, sh[3]});
    for (int f = 0; f < 4; f++) begin
      wl(5'h02, 8'h10 | 8'(f));
      rise = 6'h00;
      high = 6'h00;
      prev = calibration_wave;
      repeat (32) begin
        @(posedge clk_sys);
        rise += 6'(calibration_wave && !prev);
        high += 6'(calibration_wave);
        prev = calibration_wave;
      end
      chk({rise, high}, f == 0 ? {6'(32 >> CL), 6'h10} : f == 1 ? {6'(64 >> CL), 6'h10} :
        f == 2 ? 12'h000 : {6'h00, 6'h20});
    end
    av(1'b1, AVS_CTRL, 32'h1);
    rd(AVS_CTRL, 32'h1);
    wl(5'h04, 8'hA0);
    rd(6'h04, 32'hA3);
    rd(AVS_STATUS, 32'h1);
    av(1'b1, AVS_STATUS, 32'h1);
    rd(AVS_STATUS, 32'h0);
    wl(5'h04, 8'h55);
    rd(6'h04, 32'h55);
    av(1'b1, 6'h22, 32'hFFFFFFFF);
    rd(6'h22, 32'h0);
    repeat (4) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule : tb_afe_channel_config_regs
